// ===== logic/adc_out_pkg.sv
// Shared constants, types and helpers for the converter output block
package adc_out_pkg;

	// ==========================================================
	// Widths
	localparam int DATA_W    = 14;
	localparam int WORD_W    = 20;
	localparam int MAX_WORDS = 4;
	localparam int FRAME_W   = WORD_W * MAX_WORDS;
	localparam int RES_BASE  = 14;
	localparam int RES_STEP  = 2;

	// ==========================================================
	// Register map, byte addresses
	localparam logic [31:0] A_CTRL   = 32'h0000_0000;
	localparam logic [31:0] A_TRIG   = 32'h0000_0004;
	localparam logic [31:0] A_FREQ   = 32'h0000_0008;
	localparam logic [31:0] A_STATUS = 32'h0000_000C;

	// Trigger register bits, self clearing
	localparam int TRIG_SYNC_BIT    = 0;
	localparam int TRIG_RESTART_BIT = 1;

	// Status register fields
	localparam int STAT_PIN_BIT   = 0;
	localparam int STAT_PDN_BIT   = 1;
	localparam int STAT_PEND_BIT  = 2;
	localparam int STAT_CNT_LSB   = 8;
	localparam int STAT_CNT_W     = 8;

	// ==========================================================
	// Modes and carriers
	typedef enum logic [1:0] {
		LANES_TWO  = 2'b00,
		LANES_ONE  = 2'b01,
		LANES_HALF = 2'b10
	} lanes_t;

	typedef enum logic {
		SER_IDLE  = 1'b0,
		SER_SHIFT = 1'b1
	} ser_state_t;

	// Layout of the control register, bit 0 upward from the right
	typedef struct packed {
		logic [2:0] dec_log2;
		logic [1:0] res;
		logic       sdr;
		logic       cplx;
		lanes_t     lanes;
		logic       serial;
		logic       sync_en;
	} cfg_t;

	localparam int          CFG_W      = $bits(cfg_t);
	localparam logic [10:0] CTRL_RESET = 11'h100;

	typedef struct packed {
		logic [DATA_W-1:0] a_i;
		logic [DATA_W-1:0] a_q;
		logic [DATA_W-1:0] b_i;
		logic [DATA_W-1:0] b_q;
	} sample_t;

	typedef struct packed {
		logic [FRAME_W-1:0] bits;
		logic [6:0]         nbits;
	} frame_t;

	localparam logic [6:0] STEP_TWO = 7'h02;
	localparam logic [6:0] STEP_ONE = 7'h01;

	// ==========================================================
	// Output word length for a resolution code
	function automatic logic [6:0] word_bits(input logic [1:0] res);
		return 7'(RES_BASE + RES_STEP * int'(res));
	endfunction

	// First word sits at the top index, left aligned, MSB first; low bits beyond 14 are zero
	function automatic logic [FRAME_W-1:0] pack_frame(input logic [3:0][DATA_W-1:0] w,
		input logic [2:0] cnt, input logic [1:0] res);
		logic [FRAME_W-1:0] acc;
		int r;
		acc = '0;
		r = int'(word_bits(res));
		for (int i = 0; i < MAX_WORDS; i++) begin
			if (i < int'(cnt)) begin
				acc = acc | ({w[MAX_WORDS - 1 - i], 66'h0} >> (i * r));
			end
		end
		return acc;
	endfunction

endpackage

// ===== logic/ser_cmos_out.sv
// Serial CMOS lane shifter driven by the receiver's bit clock
`timescale 1ns/100ps
module ser_cmos_out (
	input  wire logic                   clk_in,
	input  wire logic                   rst_in,
	input  wire logic                   enable_in,
	input  wire logic                   sdr_in,
	input  wire adc_out_pkg::lanes_t    lanes_in,
	input  wire logic                   bit_clock_in,
	input  wire logic                   load_in,
	input  wire adc_out_pkg::frame_t    frame_in,
	output logic                        pending_out,
	output logic                        ret_clock_out,
	output logic                        frame_clock_out,
	output logic [1:0]                  data_out
);

	logic                            bclk_q;
	logic                            bclk_prev_q;
	logic                            half_q;
	logic                            rise;
	logic                            fall;
	logic                            tick;
	logic                            take;
	adc_out_pkg::ser_state_t         st_q;
	logic [adc_out_pkg::FRAME_W-1:0] sh_q;
	logic [adc_out_pkg::FRAME_W-1:0] src_bits;
	logic [6:0]                      left_q;
	logic [6:0]                      nb_q;
	logic [6:0]                      src_left;
	logic [6:0]                      src_nb;
	logic [6:0]                      step;
	logic                            pend_q;
	adc_out_pkg::frame_t             pend_frame_q;
	logic                            ret_q;
	logic                            frame_clock_q;
	logic [1:0]                      data_q;

	// ==========================================================
	// Bit clock edges; pin is taken as synchronous, so one stage
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			bclk_q      <= 1'b0;
			bclk_prev_q <= 1'b0;
		end else begin
			bclk_q      <= bit_clock_in;
			bclk_prev_q <= bclk_q;
		end
	end

	assign rise = bclk_q & ~bclk_prev_q;
	assign fall = ~bclk_q & bclk_prev_q;
	// Both edges by default, every second rise in single-edge mode
	assign tick = enable_in & (sdr_in ? (rise & ~half_q) : (rise | fall));
	assign step = (lanes_in == adc_out_pkg::LANES_TWO) ? adc_out_pkg::STEP_TWO
		: adc_out_pkg::STEP_ONE;

	// Divide-by-two of the fast input clock; costs up to one cycle latency
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			half_q <= 1'b0;
			ret_q  <= 1'b0;
		end else if (!enable_in) begin
			half_q <= 1'b0;
			ret_q  <= 1'b0;
		end else if (sdr_in) begin
			half_q <= half_q ^ rise;
			ret_q  <= half_q ^ rise;
		end else begin
			half_q <= 1'b0;
			ret_q  <= bclk_q;
		end
	end

	// ==========================================================
	// Frame waiting for the shifter; a new load wins over a take
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pend_q       <= 1'b0;
			pend_frame_q <= '0;
		end else if (load_in) begin
			pend_q       <= 1'b1;
			pend_frame_q <= frame_in;
		end else if (tick && take) begin
			pend_q <= 1'b0;
		end
	end

	// Source for the next tick: running frame or the waiting one
	always_comb begin
		src_bits = sh_q;
		src_left = left_q;
		src_nb   = nb_q;
		take     = 1'b0;
		if (st_q == adc_out_pkg::SER_IDLE) begin
			take     = pend_q;
			src_bits = pend_frame_q.bits;
			src_left = pend_q ? pend_frame_q.nbits : 7'h00;
			src_nb   = pend_frame_q.nbits;
		end
	end

	// ==========================================================
	// Shifter; frame clock is high over the first half of the frame
	always_ff @(posedge clk_in) begin
		if (rst_in || !enable_in) begin
			st_q   <= adc_out_pkg::SER_IDLE;
			sh_q   <= '0;
			left_q <= 7'h00;
			nb_q   <= 7'h00;
			data_q <= 2'h0;
			frame_clock_q <= 1'b0;
		end else if (tick) begin
			if (src_left != 7'h00) begin
				data_q <= (lanes_in == adc_out_pkg::LANES_TWO) ? src_bits[79:78]
					: {1'b0, src_bits[79]};
				sh_q   <= src_bits << step;
				left_q <= (src_left > step) ? 7'(src_left - step) : 7'h00;
				nb_q   <= src_nb;
				frame_clock_q <= {src_left, 1'b0} > {1'b0, src_nb};
				st_q   <= (src_left > step) ? adc_out_pkg::SER_SHIFT : adc_out_pkg::SER_IDLE;
			end else begin
				data_q <= 2'h0; // Idle lanes when starved
				frame_clock_q <= 1'b0;
			end
		end
	end

	assign pending_out     = pend_q;
	assign ret_clock_out   = ret_q;
	assign frame_clock_out = frame_clock_q;
	assign data_out        = data_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	chk_ddr_both_edges: assert property (
		enable_in && !sdr_in && st_q == adc_out_pkg::SER_SHIFT && (rise || fall)
		|=> left_q < $past(left_q))
		else $error("shift missed on a bit clock edge");

	chk_sdr_rising_only: assert property (
		enable_in && sdr_in && $stable(sdr_in) && !(rise && !half_q)
		|=> $stable(sh_q) && $stable(left_q))
		else $error("single-edge mode shifted off a returned clock rise");

	chk_sdr_half_rate: assert property (
		enable_in && sdr_in && $past(enable_in) && $past(sdr_in) && rise
		|=> ret_q != $past(ret_q))
		else $error("returned clock not half the input rate");

	chk_lane_count: assert property (
		tick && lanes_in != adc_out_pkg::LANES_TWO |=> data_q[1] == 1'b0)
		else $error("second lane driven in one-lane mode");

endmodule // ser_cmos_out

// ===== logic/adc_out_top.sv
// Converter output side: alignment, oscillator restart, DDR and serial CMOS
// Function
// - Shared pin acts as power-down or alignment input, chosen by control bit.
// - Alignment input is captured on the rising edge of the sampling clock.
// - Alignment resets decimation dividers and aligns clocks and I/Q to one sample.
// - Alignment also resets oscillator phase and loads the new frequency.
// - Parallel mode with decimation sends only real 14-bit words over DDR.
// - Parallel DDR clock is sample rate over M, data twice that rate.
// - Serial mode carries complex or real words, 8x on two, 16x on one wire.
// - Complex serial frame clock is rate over N, lanes at 2R/(L*N).
// - Real serial frame clock is rate/M/2 on two lanes, else rate/M.
// - Parallel DDR output clock is generated inside the block.
// - Serial output uses 2, 1 or one shared wire.
// - Receiver supplies the bit clock; block shifts with it and returns it.
// - Default serial data changes on both edges of the returned clock.
// - Single-edge mode needs doubled input clock, data on returned rises only.
// - Single-edge mode halves the input clock internally, maybe one cycle later.
// - Formatter places 14-bit words into 14, 16, 18 or 20 bits.
`timescale 1ns/100ps
module adc_out_top #(
	parameter int DEC_LOG2_MAX = 5
) (
	input  wire logic                      CLK_IN,
	input  wire logic                      RST_IN,
	input  wire logic                      HSEL_IN,
	input  wire logic [31:0]               HADDR_IN,
	input  wire logic [1:0]                HTRANS_IN,
	input  wire logic                      HWRITE_IN,
	input  wire logic [2:0]                HSIZE_IN,
	input  wire logic [31:0]               HWDATA_IN,
	input  wire logic                      HREADY_IN,
	output logic [31:0]                    HRDATA_OUT,
	output logic                           HREADYOUT_OUT,
	output logic                           HRESP_OUT,
	input  wire logic                      POWERDOWN_OR_ALIGN_PIN_IN,
	input  wire adc_out_pkg::sample_t      SAMPLES_IN,
	input  wire logic                      SERIAL_BIT_CLOCK_IN,
	output logic                           POWERDOWN_OUT,
	output logic [31:0]                    OSC_PHASE_OUT,
	output logic                           PAR_CLOCK_OUT,
	output logic [adc_out_pkg::DATA_W-1:0] PAR_DATA_OUT,
	output logic                           RETURNED_BIT_CLOCK_OUT,
	output logic                           FRAME_CLOCK_OUT,
	output logic [1:0]                     SER_DATA_OUT
);

	localparam int CNT_W = DEC_LOG2_MAX;

	adc_out_pkg::cfg_t       cfg_q;
	logic                    wr_pend_q;
	logic [31:0]             wr_addr_q;
	logic [31:0]             rd_data;
	logic [31:0]             hrdata_q;
	logic                    hready_q;
	logic                    hresp_q;
	logic                    ahb_go;
	logic                    sw_sync_q;
	logic                    restart_q;
	logic                    pin_q;
	logic                    pin_prev_q;
	logic                    sync_q;
	logic                    powerdown_q;
	logic [adc_out_pkg::STAT_CNT_W-1:0] sync_cnt_q;
	logic [CNT_W-1:0]        div_cnt_q;
	logic [CNT_W-1:0]        div_last;
	logic [CNT_W-1:0]        div_half;
	logic                    div_strobe;
	logic                    pair_q;
	adc_out_pkg::sample_t    cur_q;
	logic [31:0]             osc_freq_q;
	logic [31:0]             osc_active_q;
	logic [31:0]             osc_phase_q;
	logic                    par_clk_q;
	logic [adc_out_pkg::DATA_W-1:0] par_data_q;
	logic                    emit;
	logic [3:0][adc_out_pkg::DATA_W-1:0] words;
	logic [2:0]              word_cnt;
	logic                    frm_load_q;
	adc_out_pkg::frame_t     frm_q;
	logic                    ser_pending;

	// ==========================================================
	// Decimation ratio helpers; ratio one is lifted to two for DDR halves
	function automatic logic [2:0] eff_log2(input logic [2:0] l);
		if (l == 3'h0) begin
			return 3'h1;
		end else if (int'(l) > DEC_LOG2_MAX) begin
			return 3'(DEC_LOG2_MAX);
		end
		return l;
	endfunction

	function automatic logic [CNT_W-1:0] ratio_part(input logic [2:0] l, input logic half);
		logic [2:0] e;
		e = eff_log2(l);
		return half ? CNT_W'(1 << (int'(e) - 1)) : CNT_W'((1 << int'(e)) - 1);
	endfunction

	assign div_last = ratio_part(cfg_q.dec_log2, 1'b0);
	assign div_half = ratio_part(cfg_q.dec_log2, 1'b1);

	// ==========================================================
	// AHB-Lite slave: zero wait, read data latched in the address phase
	assign ahb_go = HSEL_IN & HTRANS_IN[1] & HREADY_IN;

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 32'h0000_0000;
			hrdata_q  <= 32'h0000_0000;
			hready_q  <= 1'b1;
			hresp_q   <= 1'b0;
		end else begin
			wr_pend_q <= ahb_go & HWRITE_IN;
			hready_q  <= 1'b1;
			hresp_q   <= 1'b0;
			if (ahb_go) begin
				wr_addr_q <= HADDR_IN;
			end
			hrdata_q <= (ahb_go && !HWRITE_IN) ? rd_data : 32'h0000_0000;
		end
	end

	// Read decode; unmapped addresses read zero
	always_comb begin
		rd_data = 32'h0000_0000;
		if (HADDR_IN == adc_out_pkg::A_CTRL) begin
			rd_data = 32'(cfg_q);
		end else if (HADDR_IN == adc_out_pkg::A_FREQ) begin
			rd_data = osc_freq_q;
		end else if (HADDR_IN == adc_out_pkg::A_STATUS) begin
			rd_data[adc_out_pkg::STAT_PIN_BIT]  = pin_q;
			rd_data[adc_out_pkg::STAT_PDN_BIT]  = powerdown_q;
			rd_data[adc_out_pkg::STAT_PEND_BIT] = ser_pending;
			rd_data[adc_out_pkg::STAT_CNT_LSB +: adc_out_pkg::STAT_CNT_W] = sync_cnt_q;
		end
	end

	// Register writes in the data phase
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			cfg_q      <= adc_out_pkg::cfg_t'(adc_out_pkg::CTRL_RESET);
			osc_freq_q <= 32'h0000_0000;
		end else if (wr_pend_q) begin
			if (wr_addr_q == adc_out_pkg::A_CTRL) begin
				cfg_q <= adc_out_pkg::cfg_t'(HWDATA_IN[adc_out_pkg::CFG_W-1:0]);
			end else if (wr_addr_q == adc_out_pkg::A_FREQ) begin
				osc_freq_q <= HWDATA_IN;
			end
		end
	end

	// Trigger bits give one-cycle pulses and read back as zero
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			sw_sync_q <= 1'b0;
			restart_q <= 1'b0;
		end else begin
			sw_sync_q <= wr_pend_q && wr_addr_q == adc_out_pkg::A_TRIG
				&& HWDATA_IN[adc_out_pkg::TRIG_SYNC_BIT];
			restart_q <= wr_pend_q && wr_addr_q == adc_out_pkg::A_TRIG
				&& HWDATA_IN[adc_out_pkg::TRIG_RESTART_BIT];
		end
	end

	// ==========================================================
	// Shared pin: power-down level or alignment edge
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			pin_q       <= 1'b0;
			pin_prev_q  <= 1'b0;
			powerdown_q <= 1'b0;
			sync_q      <= 1'b0;
			sync_cnt_q  <= '0;
		end else begin
			pin_q       <= POWERDOWN_OR_ALIGN_PIN_IN;
			pin_prev_q  <= pin_q;
			powerdown_q <= !cfg_q.sync_en && pin_q;
			// Pin edge and register trigger merge into one event
			sync_q <= (cfg_q.sync_en && pin_q && !pin_prev_q) || sw_sync_q;
			if (sync_q) begin
				sync_cnt_q <= sync_cnt_q + 1'b1;
			end
		end
	end

	// ==========================================================
	// Decimation divider; the event restarts it so devices line up
	assign div_strobe = (div_cnt_q == div_last);

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			div_cnt_q <= '0;
			pair_q    <= 1'b0;
		end else if (sync_q) begin
			div_cnt_q <= '0;
			pair_q    <= 1'b0;
		end else begin
			div_cnt_q <= div_strobe ? '0 : div_cnt_q + 1'b1;
			pair_q    <= div_strobe ? ~pair_q : pair_q;
		end
	end

	// I and Q of both channels are taken on the same strobe
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			cur_q <= '0;
		end else if (div_strobe) begin
			cur_q <= SAMPLES_IN;
		end
	end

	// ==========================================================
	// Oscillator: event or restart bit zero phase and load frequency
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			osc_active_q <= 32'h0000_0000;
			osc_phase_q  <= 32'h0000_0000;
		end else if (sync_q || restart_q) begin
			osc_active_q <= osc_freq_q;
			osc_phase_q  <= 32'h0000_0000;
		end else begin
			osc_phase_q <= osc_phase_q + osc_active_q;
		end
	end

	assign OSC_PHASE_OUT = osc_phase_q;

	// ==========================================================
	// Parallel DDR: own clock at rate/M, A word then B word per period
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || cfg_q.serial) begin
			par_clk_q  <= 1'b0;
			par_data_q <= '0;
		end else begin
			par_clk_q  <= div_cnt_q < div_half;
			par_data_q <= (div_cnt_q < div_half) ? cur_q.a_i : cur_q.b_i;
		end
	end

	// ==========================================================
	// Serial frame contents by mode
	always_comb begin
		words    = {SAMPLES_IN.a_i, SAMPLES_IN.a_q, SAMPLES_IN.b_i, SAMPLES_IN.b_q};
		word_cnt = 3'h2;
		emit     = div_strobe;
		if (cfg_q.cplx) begin
			// Complex: one frame per decimated sample, four words on a shared wire
			word_cnt = (cfg_q.lanes == adc_out_pkg::LANES_HALF) ? 3'h4 : 3'h2;
		end else if (cfg_q.lanes == adc_out_pkg::LANES_TWO) begin
			// Real on two lanes: previous and current sample share one frame
			words    = {cur_q.a_i, SAMPLES_IN.a_i, SAMPLES_IN.b_i, SAMPLES_IN.b_q};
			emit     = div_strobe && pair_q;
		end else if (cfg_q.lanes == adc_out_pkg::LANES_ONE) begin
			word_cnt = 3'h1;
		end else begin
			words    = {SAMPLES_IN.a_i, SAMPLES_IN.b_i, SAMPLES_IN.b_i, SAMPLES_IN.b_q};
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			frm_load_q <= 1'b0;
			frm_q      <= '0;
		end else begin
			frm_load_q <= cfg_q.serial && emit && !sync_q;
			if (emit) begin
				frm_q.bits  <= adc_out_pkg::pack_frame(words, word_cnt, cfg_q.res);
				frm_q.nbits <= 7'(int'(adc_out_pkg::word_bits(cfg_q.res)) * int'(word_cnt));
			end
		end
	end

	// Serial lanes clocked from the receiver's bit clock
	ser_cmos_out u_ser (
		.clk_in          (CLK_IN),
		.rst_in          (RST_IN),
		.enable_in       (cfg_q.serial),
		.sdr_in          (cfg_q.sdr),
		.lanes_in        (cfg_q.lanes),
		.bit_clock_in    (SERIAL_BIT_CLOCK_IN),
		.load_in         (frm_load_q),
		.frame_in        (frm_q),
		.pending_out     (ser_pending),
		.ret_clock_out   (RETURNED_BIT_CLOCK_OUT),
		.frame_clock_out (FRAME_CLOCK_OUT),
		.data_out        (SER_DATA_OUT)
	);

	assign HRDATA_OUT    = hrdata_q;
	assign HREADYOUT_OUT = hready_q;
	assign HRESP_OUT     = hresp_q;
	assign POWERDOWN_OUT = powerdown_q;
	assign PAR_CLOCK_OUT = par_clk_q;
	assign PAR_DATA_OUT  = par_data_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);

	sequence s_restarted;
		osc_phase_q == 32'h0000_0000 && osc_active_q == $past(osc_freq_q);
	endsequence

	sequence s_first_step;
		$past(sync_q || restart_q) || osc_phase_q == osc_active_q;
	endsequence

	chk_pin_powerdown: assert property (
		!cfg_q.sync_en |=> POWERDOWN_OUT == $past(pin_q))
		else $error("power-down does not follow the pin");

	chk_pin_capture: assert property (
		cfg_q.sync_en && $rose(pin_q) |=> sync_q ##1 (div_cnt_q == '0))
		else $error("pin edge did not align the divider");

	chk_divider_reset: assert property (
		sync_q |=> div_cnt_q == '0 && !pair_q)
		else $error("divider not cleared by alignment event");

	chk_osc_restart: assert property (
		(sync_q || restart_q) |=> s_restarted ##1 s_first_step)
		else $error("oscillator not restarted with new frequency");

	chk_par_clock_phase: assert property (
		!cfg_q.serial && $stable(cfg_q) && $rose(PAR_CLOCK_OUT) |-> $past(div_cnt_q) == '0)
		else $error("parallel clock edge off the divider");

	chk_par_real_word: assert property (
		$rose(PAR_CLOCK_OUT) && $stable(cfg_q) |-> PAR_DATA_OUT == cur_q.a_i)
		else $error("parallel word not the real A sample");

	chk_sw_sync_event: assert property (
		wr_pend_q && wr_addr_q == adc_out_pkg::A_TRIG
		&& HWDATA_IN[adc_out_pkg::TRIG_SYNC_BIT] |=> ##1 sync_q)
		else $error("trigger write gave no alignment event");

	chk_complex_frame: assert property (
		cfg_q.serial && cfg_q.cplx && $stable(cfg_q) && div_strobe && !sync_q
		|=> frm_load_q && frm_q.nbits == 7'(int'(adc_out_pkg::word_bits(cfg_q.res))
		* ((cfg_q.lanes == adc_out_pkg::LANES_HALF) ? 4 : 2)))
		else $error("complex frame not sent once per decimated sample");

endmodule // adc_out_top

// ===== sim/cap_rx.sv
// Capture receiver model: supplies the bit clock and collects serial words
`timescale 1ns/100ps
module cap_rx (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        run_in,
	input  wire logic        sdr_in,
	input  wire logic        ret_clock_in,
	input  wire logic        frame_clock_in,
	input  wire logic [1:0]  data_in,
	output logic             bit_clock_out,
	output logic [13:0]      word_out,
	output logic [3:0]       high_out
);
	logic [1:0]  div_q;
	logic        ret_q;
	logic        fc_q;
	logic [13:0] sh_q;
	logic [4:0]  idx_q;
	// ==========================================
	// Bit clock locked to the sampling clock; half period two cycles, one in single-edge
	always_ff @(posedge clk_in) begin
		div_q <= (run_in && !rst_in) ? div_q + 2'd1 : 2'd0;
		if (rst_in)
			bit_clock_out <= 1'b0;
		else if (run_in && (sdr_in || div_q[0]))
			bit_clock_out <= ~bit_clock_out;
	end
	// One bit per returned clock edge, rising only in single-edge mode
	always_ff @(posedge clk_in) begin
		ret_q <= ret_clock_in;
		if (rst_in) begin
			idx_q <= 5'd14;
			fc_q <= 1'b0;
			high_out <= 4'h0;
			word_out <= 14'h0000;
		end else if (ret_q != ret_clock_in && (!sdr_in || ret_clock_in)) begin
			fc_q <= frame_clock_in;
			sh_q <= {sh_q[12:0], data_in[0]};
			if (frame_clock_in && !fc_q) begin
				idx_q <= 5'd1;
				high_out <= 4'h1;
			end else begin
				idx_q <= (idx_q < 5'd14) ? idx_q + 5'd1 : idx_q;
				high_out <= high_out + 4'(frame_clock_in);
			end
			if (idx_q == 5'd13)
				word_out <= {sh_q[12:0], data_in[0]};
		end
	end
endmodule // cap_rx

// ===== sim/adc_out_top_test.sv
// Self-checking bench for the converter output block
`timescale 1ns/100ps
module adc_out_top_test;
	logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, pin = 0, run = 0, sdr = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, phase;
	logic [1:0]  htrans = 0, sdat;
	logic        rdy, resp, pdn, pclk, rclk, frame_clock, bclk;
	logic [13:0] pdata, word;
	logic [3:0]  high;
	int          n_fail = 0, checked = 0;
	int          cyc = 0;
	adc_out_pkg::sample_t smp = {14'h2A5C, 14'h1111, 14'h3C3C, 14'h0000};
	// ==========================================
	// Sampling clock, 4 ns period
	always #2 clk = ~clk;
	// Cycle count for the alignment grid
	always @(posedge clk) cyc <= cyc + 1;
	adc_out_top uut (.CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
		.HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
		.HREADY_IN(rdy), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(rdy), .HRESP_OUT(resp),
		.POWERDOWN_OR_ALIGN_PIN_IN(pin), .SAMPLES_IN(smp), .SERIAL_BIT_CLOCK_IN(bclk),
		.POWERDOWN_OUT(pdn), .OSC_PHASE_OUT(phase), .PAR_CLOCK_OUT(pclk),
		.PAR_DATA_OUT(pdata), .RETURNED_BIT_CLOCK_OUT(rclk), .FRAME_CLOCK_OUT(frame_clock),
		.SER_DATA_OUT(sdat));
	cap_rx rx (.clk_in(clk), .rst_in(rst), .run_in(run), .sdr_in(sdr), .ret_clock_in(rclk),
		.frame_clock_in(frame_clock), .data_in(sdat), .bit_clock_out(bclk),
		.word_out(word), .high_out(high));
	// ==========================================
	// Single AHB-Lite transfer; read data taken at the data-phase edge
	task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		do @(posedge clk); while (rdy !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		r = hrdata;
		cmp(32'(resp), 0);
		hwdata <= ~d;
	endtask
	// Resync toggles land on a 64-cycle grid so the divider phase stays whole
	task automatic align64;
		do @(posedge clk); while (cyc % 64 != 0);
	endtask
	task automatic cmp(input logic [31:0] g, e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Phase advance over one cycle shows the active frequency
	task automatic step(input logic [31:0] e);
		logic [31:0] p;
		@(posedge clk);
		#1 p = phase;
		@(posedge clk);
		#1 cmp(phase - p, e);
	endtask
	task summarize;
		if (n_fail == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Watchdog: the sequence needs well under 2000 cycles
	initial begin
		#20000;
		n_fail++;
		summarize();
	end
	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] rd;
		int          rises;
		logic        lastp;
		repeat (8) @(posedge clk);
		rst <= 0;
		ahb(0, adc_out_pkg::A_CTRL, 0, rd);
		cmp(rd, 32'(adc_out_pkg::CTRL_RESET));
		ahb(0, 32'h0000_0040, 0, rd);
		cmp(rd, 0);
		pin <= 1;
		repeat (3) @(posedge clk);
		#1 cmp(32'(pdn), 1);
		// Pin held high while the alignment role is chosen: power-down must drop
		ahb(1, adc_out_pkg::A_CTRL, 32'h0000_0201, rd);
		repeat (3) @(posedge clk);
		#1 cmp(32'(pdn), 0);
		pin <= 0;
		// Parallel DDR with M of 4: clock period 4, a_i high, b_i low
		rises = 0;
		lastp = pclk;
		repeat (16) begin
			@(posedge clk);
			#1 rises += int'(pclk && !lastp);
			lastp = pclk;
			cmp(32'(pdata), 32'(pclk ? smp.a_i : smp.b_i));
		end
		cmp(rises, 4);
		// Register and pin alignment; frequency only active after an event
		ahb(1, adc_out_pkg::A_FREQ, 32'h0000_0010, rd);
		align64();
		ahb(1, adc_out_pkg::A_TRIG, 32'h0000_0001, rd);
		repeat (4) @(posedge clk);
		step(32'h0000_0010);
		ahb(1, adc_out_pkg::A_FREQ, 32'h0000_0100, rd);
		step(32'h0000_0010);
		// Two cycles later so the pin event lands on the same grid phase as the write
		align64();
		repeat (2) @(posedge clk);
		pin <= 1;
		repeat (4) @(posedge clk);
		step(32'h0000_0100);
		ahb(1, adc_out_pkg::A_FREQ, 32'h0000_0040, rd);
		ahb(1, adc_out_pkg::A_TRIG, 32'h0000_0002, rd);
		repeat (4) @(posedge clk);
		step(32'h0000_0040);
		ahb(0, adc_out_pkg::A_STATUS, 0, rd);
		cmp({24'h0, rd[15:8]}, 2);
		// Serial one wire, real, 14 bits, M of 32
		pin <= 0;
		run <= 1;
		ahb(1, adc_out_pkg::A_CTRL, 32'h0000_0507, rd);
		repeat (200) @(posedge clk);
		// After the frame clock falls the high count is final until the next frame
		@(negedge frame_clock);
		@(posedge clk);
		#1 cmp(32'(word), 32'(smp.a_i));
		cmp(32'(high), 7);
		// Single-edge, complex, one wire: doubled bit clock, frames back to back
		sdr <= 1;
		ahb(1, adc_out_pkg::A_CTRL, 32'h0000_0537, rd);
		repeat (300) @(posedge clk);
		@(negedge frame_clock);
		@(posedge clk);
		#1 cmp(32'(word), 32'(smp.a_i));
		cmp(32'(high), 14);
		summarize();
	end
endmodule // adc_out_top_test
